// ==== hw/rgl_config_regs.sv ====
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
// Functional notes
// R1: parts without respiration must be written 02h at 09h; bit 1 always one.
// R2: demod_enable turns channel 1 demodulation on or off; resets off.
// R3: mod_enable turns channel 1 modulation on or off; resets off.
// R4: demod_phase_sel sets phase; top bit ignored at 64 kHz; resets zero.
// R5: breath_clock_source chooses internal clock (0) or external clock (1).
// R6: second respiration register at 0Ah: bits 6..3 zero, bit 0 one.
// R7: offset_cal_enable turns offset calibration on or off; resets off.
// R8: mod_freq_sel picks 32 or 64 kHz, only with internal clock.
// R9: bias_ref_internal picks external (0) or internal mid-supply reference (1).
// R10: io register bits 7..4 zero; pin_dir zero output, one input, resets input.
// R11: reading pin_value returns real pin levels whatever the direction.
// R12: writing pin_value drives output pins only; input pins unaffected.
// R13: in some respiration modes the io register no longer controls the pins.
// R14: external clock respiration forces both general pins to inputs.
// R15: input select 0110 routes bias feedback to positive, 0111 to negative.
// R16: electrode check selectable per input; excitation can be off, sensing on.
// R17: excite_polarity swaps current source and sink for that channel.
// R18: excite_current_mag selects dc excitation current magnitude.
// R19: comparators use 3-bit threshold code; outputs captured into electrode_status.
// R20: electrode check config and status appear in the serial output stream; the frame word carries the select register, not the config register.
// R21: comparator_powerdown in config_two powers electrode comparators down.
// R22: status bit zero means connected, one disconnected; resets zero.
// R23: fixed-value bits read back their fixed value regardless of writes.
module rgl_config_regs
    import rgl_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int ADDR_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // respiration controls
    output logic demod_enable,
    output logic mod_enable,
    output logic [3:0] demod_phase_sel,
    output logic breath_clock_source,
    output logic offset_cal_enable,
    output logic mod_freq_sel,
    output logic bias_ref_internal,
    // general purpose pins
    input wire logic [1:0] gpio_in,
    output logic [1:0] gpio_out,
    output logic [1:0] gpio_oe,
    // bias feedback routing per channel
    output logic [NUM_CH-1:0] bias_to_pos,
    output logic [NUM_CH-1:0] bias_to_neg,
    // electrode check controls
    output logic [2*NUM_CH-1:0] excite_enable,
    output logic [2*NUM_CH-1:0] sense_enable,
    output logic [NUM_CH-1:0] excite_polarity,
    output logic [1:0] excite_current_mag,
    output logic [2:0] comparator_threshold,
    output logic comparator_powerdown,
    // comparator results, one per input plus the bias drive electrode
    input wire logic [2*NUM_CH:0] comparator_out,
    // words offered to the serial output frame
    output logic [15:0] frame_status_word
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] resp_one_r;
    logic [7:0] resp_two_r;
    logic [1:0] pin_dir_r;
    logic [1:0] pin_value_r;
    logic [7:0] check_cfg_r;
    logic [7:0] check_sel_r;
    logic [7:0] cfg_two_r;
    logic [3:0] input_sel_r [NUM_CH];
    logic [2*NUM_CH:0] status_r;
    logic [1:0] gpio_meta_r;
    logic [1:0] gpio_sync_r;
    logic [2*NUM_CH:0] comp_meta_r;
    logic [2*NUM_CH:0] comp_sync_r;
    logic wr_pend_r;
    logic [7:0] wr_idx_r;
    logic ext_clk_mode;
    logic [1:0] dir_eff;
    logic addr_phase;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // word index from a byte address
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = a[ADDR_LSB+7:ADDR_LSB];
    endfunction

    // force the fixed bits of a register image to their fixed value
    function automatic logic [7:0] fix_bits(input logic [7:0] v, input logic [7:0] m, input logic [7:0] f);
        fix_bits = (v & ~m) | (f & m);
    endfunction

    // read image of one register
    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_BREATH_CLOCK_SOURCE_ONE: v = fix_bits(resp_one_r, R1_FIXED_MASK, R1_FIXED_VAL); // R23
            IDX_BREATH_CLOCK_SOURCE_TWO: v = fix_bits(resp_two_r, R2_FIXED_MASK, R2_FIXED_VAL); // R23
            IDX_GENERAL_IO: v = {4'h0, pin_dir_r, gpio_sync_r}; // R11
            IDX_ELECTRODE_CHECK_CFG: v = check_cfg_r;
            IDX_ELECTRODE_CHECK_SELECT: v = check_sel_r;
            IDX_CONFIG_TWO: v = cfg_two_r;
            IDX_ELECTRODE_STATUS: v = 8'(status_r); // R22
            IDX_CH1_INPUT_SEL: v = {4'h0, input_sel_r[0]};
            IDX_CH2_INPUT_SEL: v = {4'h0, input_sel_r[NUM_CH-1]};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign addr_phase = hsel & hready & htrans[1];
    // external clock respiration takes the pins away from the io register
    assign ext_clk_mode = resp_one_r[R1_CLK_SRC_BIT]; // R5
    assign dir_eff = ext_clk_mode ? 2'h3 : pin_dir_r; // R13 R14

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    // capture the address phase, answer with zero wait states
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0; // always okay, unmapped reads zero
            wr_pend_r <= addr_phase & hwrite;
            wr_idx_r <= word_idx(haddr);
            if (addr_phase && !hwrite) begin
                hrdata <= {24'h000000, read_reg(word_idx(haddr))};
            end
        end
    end

    // ---------------------------------------------------------------
    // respiration registers
    // ---------------------------------------------------------------
    // fixed bits are stored at their fixed value whatever is written, so logic and readback only see that value
    always_ff @(posedge clk) begin
        if (srst) begin
            resp_one_r <= R1_RESET; // R2 R3 R4
            resp_two_r <= R2_RESET; // R7 R9
        end else if (wr_pend_r) begin
            if (wr_idx_r == IDX_BREATH_CLOCK_SOURCE_ONE) begin
                resp_one_r <= fix_bits(hwdata[7:0], R1_FIXED_MASK, R1_FIXED_VAL); // R1
            end
            if (wr_idx_r == IDX_BREATH_CLOCK_SOURCE_TWO) begin
                resp_two_r <= fix_bits(hwdata[7:0], R2_FIXED_MASK, R2_FIXED_VAL); // R6
            end
        end
    end

    // decoded respiration controls
    always_ff @(posedge clk) begin
        if (srst) begin
            demod_enable <= 1'b0;
            mod_enable <= 1'b0;
            demod_phase_sel <= 4'h0;
            breath_clock_source <= 1'b0;
            offset_cal_enable <= 1'b0;
            mod_freq_sel <= 1'b0;
            bias_ref_internal <= 1'b1;
        end else begin
            demod_enable <= resp_one_r[R1_DEMOD_EN_BIT]; // R2
            mod_enable <= resp_one_r[R1_MOD_EN_BIT]; // R3
            breath_clock_source <= resp_one_r[R1_CLK_SRC_BIT]; // R5
            offset_cal_enable <= resp_two_r[R2_CAL_EN_BIT]; // R7
            bias_ref_internal <= resp_two_r[R2_BIAS_REF_BIT]; // R9
            // frequency select only counts with the internal clock
            mod_freq_sel <= resp_two_r[R2_FREQ_BIT] & ~ext_clk_mode; // R8
            // at 64 kHz the top phase bit is ignored
            if (resp_two_r[R2_FREQ_BIT] && !ext_clk_mode) begin
                demod_phase_sel <= {1'b0, resp_one_r[R1_PHASE_HI-1:R1_PHASE_LO]}; // R4
            end else begin
                demod_phase_sel <= resp_one_r[R1_PHASE_HI:R1_PHASE_LO]; // R4
            end
        end
    end

    // ---------------------------------------------------------------
    // general purpose io
    // ---------------------------------------------------------------
    // two-stage synchroniser for the pin levels
    always_ff @(posedge clk) begin
        if (srst) begin
            gpio_meta_r <= 2'h0;
            gpio_sync_r <= 2'h0;
        end else begin
            gpio_meta_r <= gpio_in;
            gpio_sync_r <= gpio_meta_r;
        end
    end

    // direction and output latch
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_dir_r <= GIO_DIR_RESET; // R10
            pin_value_r <= GIO_VAL_RESET;
        end else if (wr_pend_r && wr_idx_r == IDX_GENERAL_IO) begin
            pin_dir_r <= hwdata[GIO_DIR_LO+1:GIO_DIR_LO]; // R10
            for (int i = 0; i < 2; i++) begin
                if (!dir_eff[i]) begin
                    pin_value_r[i] <= hwdata[GIO_VAL_LO+i]; // R12
                end
            end
        end
    end

    // pin drivers; enable high means driving
    always_ff @(posedge clk) begin
        if (srst) begin
            gpio_out <= 2'h0;
            gpio_oe <= 2'h0;
        end else begin
            gpio_out <= pin_value_r;
            gpio_oe <= ~dir_eff; // R10 R13 R14
        end
    end

    // ---------------------------------------------------------------
    // electrode check and routing registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            check_cfg_r <= CFG_RESET;
            check_sel_r <= SEL_RESET;
            cfg_two_r <= C2_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
                input_sel_r[c] <= MUX_RESET;
            end
        end else if (wr_pend_r) begin
            if (wr_idx_r == IDX_ELECTRODE_CHECK_CFG) begin
                check_cfg_r <= hwdata[7:0];
            end
            if (wr_idx_r == IDX_ELECTRODE_CHECK_SELECT) begin
                check_sel_r <= hwdata[7:0];
            end
            if (wr_idx_r == IDX_CONFIG_TWO) begin
                cfg_two_r <= hwdata[7:0];
            end
            if (wr_idx_r == IDX_CH1_INPUT_SEL) begin
                input_sel_r[0] <= hwdata[3:0];
            end
            if (wr_idx_r == IDX_CH2_INPUT_SEL) begin
                input_sel_r[NUM_CH-1] <= hwdata[3:0];
            end
        end
    end

    // decoded electrode check and routing controls
    always_ff @(posedge clk) begin
        if (srst) begin
            bias_to_pos <= '0;
            bias_to_neg <= '0;
            excite_enable <= '0;
            sense_enable <= '0;
            excite_polarity <= '0;
            excite_current_mag <= 2'h0;
            comparator_threshold <= 3'h0;
            comparator_powerdown <= 1'b0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                bias_to_pos[c] <= (input_sel_r[c] == MUX_BIAS_TO_POS); // R15
                bias_to_neg[c] <= (input_sel_r[c] == MUX_BIAS_TO_NEG); // R15
                excite_polarity[c] <= check_sel_r[SEL_FLIP_LO+c]; // R17
            end
            sense_enable <= check_sel_r[2*NUM_CH-1:0]; // R16
            // excitation may be switched off while sensing stays on
            excite_enable <= check_sel_r[2*NUM_CH-1:0] & {(2*NUM_CH){~check_cfg_r[CFG_EXCITE_OFF_BIT]}}; // R16
            excite_current_mag <= check_cfg_r[CFG_MAG_HI:CFG_MAG_LO]; // R18
            comparator_threshold <= check_cfg_r[CFG_THRESH_HI:CFG_THRESH_LO]; // R19
            comparator_powerdown <= cfg_two_r[C2_COMP_PD_BIT]; // R21
        end
    end

    // ---------------------------------------------------------------
    // comparator capture and frame word
    // ---------------------------------------------------------------
    // comparators are asynchronous to clk
    always_ff @(posedge clk) begin
        if (srst) begin
            comp_meta_r <= '0;
            comp_sync_r <= '0;
        end else begin
            comp_meta_r <= comparator_out;
            comp_sync_r <= comp_meta_r;
        end
    end

    // powered-down comparators report connected
    always_ff @(posedge clk) begin
        if (srst) begin
            status_r <= '0; // R22
        end else if (cfg_two_r[C2_COMP_PD_BIT]) begin
            status_r <= '0; // R21
        end else begin
            status_r <= comp_sync_r; // R19 R22
        end
    end

    // electrode check select register and status handed to the serial output frame
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_status_word <= 16'h0000;
        end else begin
            frame_status_word <= {check_sel_r, 8'(status_r)}; // R20
        end
    end

endmodule

// ==== hw/rgl_pkg.sv ====
package rgl_pkg;
    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_CONFIG_TWO = 8'h02;
    localparam logic [7:0] IDX_ELECTRODE_CHECK_CFG = 8'h04;
    localparam logic [7:0] IDX_CH1_INPUT_SEL = 8'h05;
    localparam logic [7:0] IDX_CH2_INPUT_SEL = 8'h06;
    localparam logic [7:0] IDX_ELECTRODE_CHECK_SELECT = 8'h07;
    localparam logic [7:0] IDX_ELECTRODE_STATUS = 8'h08;
    localparam logic [7:0] IDX_BREATH_CLOCK_SOURCE_ONE = 8'h09;
    localparam logic [7:0] IDX_BREATH_CLOCK_SOURCE_TWO = 8'h0a;
    localparam logic [7:0] IDX_GENERAL_IO = 8'h0b;
    localparam int ADDR_LSB = 2;

    // ---------------------------------------------------------------
    // respiration control one fields
    // ---------------------------------------------------------------
    localparam int R1_DEMOD_EN_BIT = 7;
    localparam int R1_MOD_EN_BIT = 6;
    localparam int R1_PHASE_HI = 5;
    localparam int R1_PHASE_LO = 2;
    localparam int R1_FIXED_ONE_BIT = 1;
    localparam int R1_CLK_SRC_BIT = 0;
    localparam logic [7:0] R1_FIXED_MASK = 8'h02;
    localparam logic [7:0] R1_FIXED_VAL = 8'h02;
    localparam logic [7:0] R1_RESET = 8'h02;

    // ---------------------------------------------------------------
    // respiration control two fields
    // ---------------------------------------------------------------
    localparam int R2_CAL_EN_BIT = 7;
    localparam int R2_FREQ_BIT = 2;
    localparam int R2_BIAS_REF_BIT = 1;
    localparam logic [7:0] R2_FIXED_MASK = 8'h79;
    localparam logic [7:0] R2_FIXED_VAL = 8'h01;
    localparam logic [7:0] R2_RESET = 8'h03;

    // ---------------------------------------------------------------
    // general io fields
    // ---------------------------------------------------------------
    localparam int GIO_DIR_LO = 2;
    localparam int GIO_VAL_LO = 0;
    localparam logic [7:0] GIO_FIXED_MASK = 8'hf0;
    localparam logic [1:0] GIO_DIR_RESET = 2'h3;
    localparam logic [1:0] GIO_VAL_RESET = 2'h0;

    // ---------------------------------------------------------------
    // electrode check fields
    // ---------------------------------------------------------------
    localparam int CFG_THRESH_HI = 7;
    localparam int CFG_THRESH_LO = 5;
    localparam int CFG_MAG_HI = 3;
    localparam int CFG_MAG_LO = 2;
    localparam int CFG_EXCITE_OFF_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int SEL_FLIP_LO = 4;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam int C2_COMP_PD_BIT = 6;
    localparam logic [7:0] C2_RESET = 8'h00;
    localparam int STAT_BIAS_BIT = 4;

    // ---------------------------------------------------------------
    // channel input select codes
    // ---------------------------------------------------------------
    localparam logic [3:0] MUX_BIAS_TO_POS = 4'h6;
    localparam logic [3:0] MUX_BIAS_TO_NEG = 4'h7;
    localparam logic [3:0] MUX_RESET = 4'h0;
endpackage

// ==== testbench/rgl_config_regs_checker.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// register bank checker
// ---------------------------------------------------------------
module rgl_regs_checker
    import rgl_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // respiration outputs
    input wire logic demod_enable,
    input wire logic mod_enable,
    input wire logic [3:0] demod_phase_sel,
    input wire logic breath_clock_source,
    input wire logic mod_freq_sel,
    input wire logic bias_ref_internal,
    // pins and routing
    input wire logic [1:0] gpio_oe,
    input wire logic [NUM_CH-1:0] bias_to_pos,
    input wire logic [NUM_CH-1:0] bias_to_neg,
    // electrode check
    input wire logic [2*NUM_CH-1:0] excite_enable,
    input wire logic [2*NUM_CH-1:0] sense_enable,
    input wire logic [NUM_CH-1:0] excite_polarity,
    input wire logic comparator_powerdown,
    input wire logic [15:0] frame_status_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // held modes, long enough for decoded outputs to follow
    sequence ext_held;
        breath_clock_source [*3];
    endsequence
    sequence fast_held;
        mod_freq_sel [*3];
    endsequence

    a_reset_outputs: assert property ($past(srst) |-> !demod_enable && !mod_enable && bias_ref_internal && gpio_oe == 2'h0)
        else $error("outputs not at reset values");
    a_ext_pins_input: assert property (ext_held |-> gpio_oe == 2'h0)
        else $error("pin driven in external clock mode");
    a_ext_no_fast: assert property (ext_held |-> !mod_freq_sel)
        else $error("fast modulation with external clock");
    a_fast_phase_top: assert property (fast_held |-> !demod_phase_sel[3])
        else $error("phase top bit set at fast modulation");
    a_bias_route_excl: assert property ((bias_to_pos & bias_to_neg) == '0)
        else $error("bias feedback routed to both inputs");
    a_excite_needs_sense: assert property ((excite_enable & ~sense_enable) == '0)
        else $error("excitation without sensing selected");
    a_powerdown_status: assert property (comparator_powerdown [*6] |-> frame_status_word[7:0] == 8'h00)
        else $error("status set while comparators powered down");
    a_frame_select: assert property ($past(sense_enable) == sense_enable && $past(sense_enable, 2) == sense_enable
        && $past(excite_polarity) == excite_polarity |-> frame_status_word[8 +: 3*NUM_CH] == {excite_polarity, sense_enable})
        else $error("frame word disagrees with selection");
endmodule

bind rgl_config_regs rgl_regs_checker #(.NUM_CH(NUM_CH)) u_checker (
    .clk(clk), .srst(srst), .demod_enable(demod_enable), .mod_enable(mod_enable),
    .demod_phase_sel(demod_phase_sel), .breath_clock_source(breath_clock_source),
    .mod_freq_sel(mod_freq_sel), .bias_ref_internal(bias_ref_internal), .gpio_oe(gpio_oe),
    .bias_to_pos(bias_to_pos), .bias_to_neg(bias_to_neg), .excite_enable(excite_enable),
    .sense_enable(sense_enable), .excite_polarity(excite_polarity),
    .comparator_powerdown(comparator_powerdown), .frame_status_word(frame_status_word)
);

// ==== testbench/test_resp_gpio_leadoff_config.sv ====
`timescale 1ns/10ps
module test_resp_gpio_leadoff_config;
    import rgl_pkg::*;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] gpio_in = 2'h2;
    logic [4:0] comparator_out = 5'h00;
    wire hready_w;
    logic hresp, demod_enable, mod_enable, breath_clock_source, offset_cal_enable, mod_freq_sel;
    logic bias_ref_internal, comparator_powerdown;
    logic [31:0] hrdata;
    logic [3:0] demod_phase_sel, excite_enable, sense_enable;
    logic [1:0] gpio_out, gpio_oe, bias_to_pos, bias_to_neg, excite_polarity, excite_current_mag;
    logic [2:0] comparator_threshold;
    logic [15:0] frame_status_word;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;

    // the one slave's ready is the bus ready
    rgl_config_regs dut (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready_w), .hreadyout(hready_w), .hresp(hresp),
        .hrdata(hrdata), .demod_enable(demod_enable), .mod_enable(mod_enable),
        .demod_phase_sel(demod_phase_sel), .breath_clock_source(breath_clock_source),
        .offset_cal_enable(offset_cal_enable), .mod_freq_sel(mod_freq_sel),
        .bias_ref_internal(bias_ref_internal), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .bias_to_pos(bias_to_pos), .bias_to_neg(bias_to_neg),
        .excite_enable(excite_enable), .sense_enable(sense_enable),
        .excite_polarity(excite_polarity), .excite_current_mag(excite_current_mag),
        .comparator_threshold(comparator_threshold), .comparator_powerdown(comparator_powerdown),
        .comparator_out(comparator_out), .frame_status_word(frame_status_word)
    );

    // clock generator
    initial begin
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single ahb transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hready_w !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hready_w !== 1'b1) @(posedge clk);
        rd = hrdata[7:0];
        chk(16'(hresp), 16'h0);
        chk(16'(|hrdata[31:8]), 16'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        xfer(idx, 1'b1, d, unused);
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        xfer(idx, 1'b0, 8'h00, v);
        chk(16'(v), 16'(exp));
    endtask

    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_reset();
        rd_chk(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h02);
        rd_chk(IDX_BREATH_CLOCK_SOURCE_TWO, 8'h03);
        rd_chk(IDX_GENERAL_IO, 8'h0e);
        rd_chk(IDX_ELECTRODE_STATUS, 8'h00);
        rd_chk(8'h1f, 8'h00);
        chk(16'({gpio_oe, bias_ref_internal}), 16'h1);
    endtask

    task automatic test_fixed();
        wr(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h00);
        rd_chk(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h02);
        wr(IDX_BREATH_CLOCK_SOURCE_TWO, 8'hff);
        rd_chk(IDX_BREATH_CLOCK_SOURCE_TWO, 8'h87);
        wr(IDX_BREATH_CLOCK_SOURCE_TWO, 8'h00);
        rd_chk(IDX_BREATH_CLOCK_SOURCE_TWO, 8'h01);
        wr(IDX_GENERAL_IO, 8'hfc);
        rd_chk(IDX_GENERAL_IO, 8'h0e);
    endtask

    // every phase code at both modulation rates
    task automatic test_resp();
        for (int f = 0; f < 2; f++) begin
            wr(IDX_BREATH_CLOCK_SOURCE_TWO, {5'h0, f[0], 2'h1});
            for (int p = 0; p < 16; p++) begin
                wr(IDX_BREATH_CLOCK_SOURCE_ONE, {2'h3, 4'(p), 2'h2});
                settle();
                chk(16'(demod_phase_sel), 16'(f == 1 ? p % 8 : p));
                chk(16'({demod_enable, mod_enable, mod_freq_sel, bias_ref_internal}), 16'({2'h3, f[0], 1'b0}));
            end
        end
        wr(IDX_BREATH_CLOCK_SOURCE_TWO, 8'h87);
        wr(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h03);
        settle();
        chk(16'({offset_cal_enable, breath_clock_source, mod_freq_sel, bias_ref_internal, demod_enable}), 16'h1a);
        rd_chk(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h03);
    endtask

    task automatic test_gpio();
        wr(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h02);
        wr(IDX_GENERAL_IO, 8'h01);
        gpio_in <= 2'h1;
        settle();
        // pins were still inputs when the value was written, so it is dropped
        chk(16'({gpio_oe, gpio_out}), 16'hc);
        wr(IDX_GENERAL_IO, 8'h01);
        settle();
        chk(16'({gpio_oe, gpio_out}), 16'hd);
        rd_chk(IDX_GENERAL_IO, 8'h01);
        wr(IDX_GENERAL_IO, 8'h05);
        wr(IDX_GENERAL_IO, 8'h06);
        settle();
        chk(16'({gpio_oe, gpio_out}), 16'hb);
        wr(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h03);
        wr(IDX_GENERAL_IO, 8'h00);
        settle();
        chk(16'({gpio_oe, gpio_out}), 16'h3);
        rd_chk(IDX_GENERAL_IO, 8'h01);
        wr(IDX_BREATH_CLOCK_SOURCE_ONE, 8'h02);
        settle();
        chk(16'({gpio_oe, gpio_out}), 16'hf);
        wr(IDX_GENERAL_IO, 8'h0c);
    endtask

    task automatic test_leadoff();
        logic [3:0] codes [3] = '{4'h6, 4'h7, 4'h0};
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < 3; i++) begin
                wr(8'(IDX_CH1_INPUT_SEL + ch), {4'h0, codes[i]});
                settle();
                chk(16'({bias_to_pos, bias_to_neg}), 16'(i == 0 ? 4 << ch : (i == 1 ? 1 << ch : 0)));
            end
        end
        wr(IDX_ELECTRODE_CHECK_SELECT, 8'h3f);
        wr(IDX_ELECTRODE_CHECK_CFG, 8'ha9);
        settle();
        chk(16'({excite_enable, sense_enable, excite_polarity, excite_current_mag, comparator_threshold}), 16'h07f5);
        wr(IDX_ELECTRODE_CHECK_CFG, 8'ha8);
        comparator_out <= 5'h15;
        settle();
        chk(16'(excite_enable), 16'hf);
        rd_chk(IDX_ELECTRODE_STATUS, 8'h15);
        chk(frame_status_word, 16'h3f15);
        wr(IDX_CONFIG_TWO, 8'h40);
        settle();
        chk(16'(comparator_powerdown), 16'h1);
        rd_chk(IDX_ELECTRODE_STATUS, 8'h00);
        wr(IDX_CONFIG_TWO, 8'h00);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        test_reset();
        test_fixed();
        test_resp();
        test_gpio();
        test_leadoff();
        report_and_stop();
    end
endmodule
